// ### src/sbtc_top.sv
// sixteen bit timer/counter with prescaler, crystal oscillator and compare clear
`timescale 1ns/100ps
`default_nettype none
module sbtc_top (
    // clock and power-on/brown-out reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // other resets and power state, same clock domain
    input  wire logic        soft_reset_n,
    input  wire logic        sleep_req,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    input  wire logic        ext_clock_pin,
    input  wire logic        osc_input_pin,
    output logic             osc_output_pin,
    output logic             osc_enable,
    // interrupt to the processor
    output logic             irq
);
    sbtc_pkg::sbtc_state_s s_q;      // registered control state
    sbtc_pkg::sbtc_state_s s_d;      // next control state
    logic [15:0]           count_q;  // timer count, never reset
    logic [15:0]           count_d;  // next count

    sbtc_if pif ();                  // prescaler link

    // register decode, used by the read mux, write strobes and error answer
    function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
        hit = (a[11:2] == idx) && (a[1:0] == 2'h0);
    endfunction : hit

    // true for any mapped register
    function automatic logic mapped(input logic [11:0] a);
        mapped = hit(a, sbtc_pkg::IDX_INTCTL) || hit(a, sbtc_pkg::IDX_PFLAGS)
              || hit(a, sbtc_pkg::IDX_CNT_LO) || hit(a, sbtc_pkg::IDX_CNT_HI)
              || hit(a, sbtc_pkg::IDX_TCTL)   || hit(a, sbtc_pkg::IDX_CMP_LO)
              || hit(a, sbtc_pkg::IDX_CMP_HI) || hit(a, sbtc_pkg::IDX_CMP_MODE)
              || hit(a, sbtc_pkg::IDX_PENABLES);
    endfunction : mapped

    // apb write strobes, taken at the access edge only
    logic wr_en;       // any accepted write
    logic wr_cnt_lo;   // low count byte write
    logic wr_cnt_hi;   // high count byte write
    logic wr_cnt;      // either count byte written
    logic wr_tctl;     // control register write
    assign wr_en     = psel && penable && pwrite && mapped(paddr);
    assign wr_cnt_lo = wr_en && hit(paddr, sbtc_pkg::IDX_CNT_LO);
    assign wr_cnt_hi = wr_en && hit(paddr, sbtc_pkg::IDX_CNT_HI);
    assign wr_cnt    = wr_cnt_lo || wr_cnt_hi;
    assign wr_tctl   = wr_en && hit(paddr, sbtc_pkg::IDX_TCTL);

    // apb answers: zero wait, data captured during setup
    assign pready  = 1'b1;
    assign prdata  = s_q.rdata;
    assign pslverr = psel && penable && !mapped(paddr);

    // control field views
    logic       timer_on;   // timer_on_bit
    logic       src_ext;    // clock_source_select
    logic       async_mode; // ext_sync_control set
    logic [1:0] presc_sel;  // prescale_select
    assign timer_on   = s_q.tctl[sbtc_pkg::BIT_ON];
    assign src_ext    = s_q.tctl[sbtc_pkg::BIT_SRC];
    assign async_mode = s_q.tctl[sbtc_pkg::BIT_ASYNC];
    assign presc_sel  = s_q.tctl[sbtc_pkg::PS_LSB +: 2];

    // oscillator amplifier: sleep is not an input here, so it runs on
    assign osc_enable     = s_q.tctl[sbtc_pkg::BIT_OSC_EN];
    assign osc_output_pin = osc_enable && !osc_input_pin;

    // external source is the oscillator when it is on, else the clock pin
    logic ext_src;  // raw pin level before synchronising
    assign ext_src = osc_enable ? osc_input_pin : ext_clock_pin;

    // rising edge seen after the two synchroniser stages
    logic ext_rise;
    assign ext_rise = s_q.sync[1] && !s_q.sync[2];

    // source tick: instruction clock stops in sleep; async counting goes on
    logic src_tick;
    always_comb begin
        if (src_ext) begin
            src_tick = ext_rise && (async_mode || !sleep_req);
        end else begin
            src_tick = (s_q.icyc == sbtc_pkg::ICYC_LAST) && !sleep_req;
        end
    end

    // prescaler hookup
    assign pif.src_tick = src_tick && timer_on;
    assign pif.sel      = presc_sel;
    assign pif.clr      = wr_cnt;

    sbtc_presc u_presc (
        .pclk    (pclk),
        .presetn (presetn),
        .pif     (pif.presc)
    );

    // compare match: pair is the period; not promised in async mode
    logic trig;
    assign trig = (s_q.cmp_mode == sbtc_pkg::CMP_MODE_TRIG) && timer_on && !async_mode
               && (count_q == {s_q.cmp_hi, s_q.cmp_lo});

    // overflow only from a real wrap, never from the trigger clear
    logic ovf_evt;
    assign ovf_evt = pif.tick && (count_q == 16'hffff) && !trig && !wr_cnt;

    // count: write first, then trigger clear, then increment
    always_comb begin
        count_d = count_q;
        if (wr_cnt_lo) begin
            count_d[7:0] = pwdata[7:0];
        end else if (wr_cnt_hi) begin
            count_d[15:8] = pwdata[7:0];
        end else if (trig) begin
            count_d = 16'h0000;
        end else if (pif.tick) begin
            count_d = count_q + 16'h0001;
        end
    end

    // the count has no reset branch, so no reset of any kind touches it
    always_ff @(posedge pclk) begin
        count_q <= count_d;
    end

    // read mux for the setup-phase capture
    function automatic logic [7:0] rd_byte(input logic [11:0] a,
                                           input sbtc_pkg::sbtc_state_s s,
                                           input logic [15:0] c);
        rd_byte = 8'h00;
        if (hit(a, sbtc_pkg::IDX_INTCTL))   rd_byte = s.intctl;
        if (hit(a, sbtc_pkg::IDX_PFLAGS))   rd_byte = s.pflags;
        if (hit(a, sbtc_pkg::IDX_PENABLES)) rd_byte = s.penables;
        if (hit(a, sbtc_pkg::IDX_CNT_LO))   rd_byte = c[7:0];
        if (hit(a, sbtc_pkg::IDX_CNT_HI))   rd_byte = c[15:8];
        if (hit(a, sbtc_pkg::IDX_TCTL))     rd_byte = {2'h0, s.tctl};
        if (hit(a, sbtc_pkg::IDX_CMP_LO))   rd_byte = s.cmp_lo;
        if (hit(a, sbtc_pkg::IDX_CMP_HI))   rd_byte = s.cmp_hi;
        if (hit(a, sbtc_pkg::IDX_CMP_MODE)) rd_byte = {4'h0, s.cmp_mode};
    endfunction : rd_byte

    // next control state
    always_comb begin
        s_d = s_q;
        // pin synchroniser; stage 0 is read only by stage 1
        s_d.sync = {s_q.sync[1:0], ext_src};
        // instruction clock phase
        s_d.icyc = s_q.icyc + 2'h1;
        // read data caught in the setup cycle
        if (psel && !penable) begin
            s_d.rdata = {24'h00_0000, rd_byte(paddr, s_q, count_q)};
        end
        // software writes
        if (wr_en && hit(paddr, sbtc_pkg::IDX_INTCTL)) begin
            s_d.intctl = pwdata[7:0];
        end
        if (wr_en && hit(paddr, sbtc_pkg::IDX_PFLAGS)) begin
            s_d.pflags = s_q.pflags & ~(pwdata[7:0] & sbtc_pkg::FLAG_MASK);
        end
        if (wr_en && hit(paddr, sbtc_pkg::IDX_PENABLES)) begin
            s_d.penables = pwdata[7:0] & sbtc_pkg::FLAG_MASK;
        end
        if (wr_tctl) begin
            s_d.tctl = pwdata[5:0];
        end
        if (wr_en && hit(paddr, sbtc_pkg::IDX_CMP_LO)) begin
            s_d.cmp_lo = pwdata[7:0];
        end
        if (wr_en && hit(paddr, sbtc_pkg::IDX_CMP_HI)) begin
            s_d.cmp_hi = pwdata[7:0];
        end
        if (wr_en && hit(paddr, sbtc_pkg::IDX_CMP_MODE)) begin
            s_d.cmp_mode = pwdata[3:0];
        end
        // other resets clear interrupt state but keep the control register
        if (!soft_reset_n) begin
            s_d.intctl[7:1] = 7'h00;
            s_d.pflags      = sbtc_pkg::PFLAGS_RESET;
            s_d.penables    = sbtc_pkg::PENABLES_RESET;
        end
        // events set flags after the clear, so a coincident set survives
        if (ovf_evt) begin
            s_d.pflags[sbtc_pkg::FLAG_OVF] = 1'b1;
        end
        if (trig) begin
            s_d.pflags[sbtc_pkg::FLAG_CMP] = 1'b1;
        end
    end

    // state register; presetn stands for power-on and brown-out reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q          <= '0;
            s_q.intctl   <= sbtc_pkg::INTCTL_RESET;
            s_q.pflags   <= sbtc_pkg::PFLAGS_RESET;
            s_q.penables <= sbtc_pkg::PENABLES_RESET;
            s_q.tctl     <= sbtc_pkg::TCTL_RESET;
            s_q.cmp_lo   <= sbtc_pkg::CMP_RESET;
            s_q.cmp_hi   <= sbtc_pkg::CMP_RESET;
            s_q.cmp_mode <= sbtc_pkg::CMP_MODE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // interrupt: masked flags, then peripheral and global enables
    always_comb begin
        irq = s_q.intctl[sbtc_pkg::BIT_GLOBAL_EN] && s_q.intctl[sbtc_pkg::BIT_PERIPH_EN]
           && |(s_q.pflags & s_q.penables);
    end

    // checks next to the logic they guard
    a_osc_follow: assert property (@(posedge pclk) disable iff (!presetn)
        wr_tctl |=> osc_enable == $past(pwdata[3])) else $error("osc enable mismatch");
    a_osc_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        (osc_enable && sleep_req && !wr_tctl) |=> osc_enable)
        else $error("osc stopped in sleep");
    a_trig_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (trig && !wr_cnt) |=> count_q == 16'h0000) else $error("trigger did not clear");
    a_trig_noovf: assert property (@(posedge pclk) disable iff (!presetn)
        (trig && !s_q.pflags[0] && !$past(ovf_evt)) |=> !s_q.pflags[0])
        else $error("trigger set overflow");
    a_async_notrig: assert property (@(posedge pclk) disable iff (!presetn)
        async_mode |-> !trig) else $error("trigger in async mode");
    a_write_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (trig && wr_cnt_lo) |=> count_q[7:0] == $past(pwdata[7:0]))
        else $error("clear beat write");
    a_ctl_reset: assert property (@(posedge pclk)
        $rose(presetn) |-> s_q.tctl == 6'h00) else $error("control not reset");
    a_ctl_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (!soft_reset_n && !wr_tctl) |=> $stable(s_q.tctl))
        else $error("other reset changed control");
    a_hi_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cnt_hi |=> count_q[15:8] == $past(pwdata[7:0]))
        else $error("high byte write lost");
    a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        (ovf_evt && soft_reset_n) |=> s_q.pflags[0]) else $error("overflow flag not set");
    a_global_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.intctl[7] |-> !irq) else $error("irq without global enable");
    a_count_inc: assert property (@(posedge pclk) disable iff (!presetn)
        (pif.tick && !trig && !wr_cnt) |=> count_q == $past(count_q) + 16'h0001)
        else $error("count did not advance");
    a_irq_cause: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> s_q.intctl[6] && ((s_q.pflags[0] && s_q.penables[0])
                               || (s_q.pflags[2] && s_q.penables[2])))
        else $error("irq without cause");
endmodule : sbtc_top
`default_nettype wire

// ### common/sbtc_pkg.sv
// constants and state types shared by the timer/counter design
package sbtc_pkg;
    // apb address width and register indexes (byte address = 4 * index)
    localparam int unsigned ADDR_W        = 12;
    localparam logic [9:0]  IDX_INTCTL    = 10'h00b;
    localparam logic [9:0]  IDX_PFLAGS    = 10'h00c;
    localparam logic [9:0]  IDX_CNT_LO    = 10'h00e;
    localparam logic [9:0]  IDX_CNT_HI    = 10'h00f;
    localparam logic [9:0]  IDX_TCTL      = 10'h010;
    localparam logic [9:0]  IDX_CMP_LO    = 10'h015;
    localparam logic [9:0]  IDX_CMP_HI    = 10'h016;
    localparam logic [9:0]  IDX_CMP_MODE  = 10'h017;
    localparam logic [9:0]  IDX_PENABLES  = 10'h08c;

    // interrupt control fields
    localparam int unsigned BIT_GLOBAL_EN = 7;
    localparam int unsigned BIT_PERIPH_EN = 6;
    localparam logic [7:0]  INTCTL_RESET  = 8'h00;

    // peripheral flag and enable layout
    localparam int unsigned FLAG_OVF      = 0;
    localparam int unsigned FLAG_CMP      = 2;
    localparam logic [7:0]  FLAG_MASK     = 8'h05;
    localparam logic [7:0]  PFLAGS_RESET  = 8'h00;
    localparam logic [7:0]  PENABLES_RESET = 8'h00;

    // timer control fields
    localparam int unsigned BIT_ON        = 0;
    localparam int unsigned BIT_SRC       = 1;
    localparam int unsigned BIT_ASYNC     = 2;
    localparam int unsigned BIT_OSC_EN    = 3;
    localparam int unsigned PS_LSB        = 4;
    localparam logic [5:0]  TCTL_RESET    = 6'h00;

    // compare unit
    localparam logic [3:0]  CMP_MODE_TRIG = 4'hb;
    localparam logic [3:0]  CMP_MODE_RESET = 4'h0;
    localparam logic [7:0]  CMP_RESET     = 8'h00;

    // instruction clock is the core clock divided by four
    localparam int unsigned INSTR_DIV     = 4;
    localparam logic [1:0]  ICYC_LAST     = 2'(INSTR_DIV - 1);

    // register state of the top module
    typedef struct packed {
        logic [7:0]  intctl;
        logic [7:0]  pflags;
        logic [7:0]  penables;
        logic [5:0]  tctl;
        logic [7:0]  cmp_lo;
        logic [7:0]  cmp_hi;
        logic [3:0]  cmp_mode;
        logic [1:0]  icyc;
        logic [2:0]  sync;
        logic [31:0] rdata;
    } sbtc_state_s;

    // prescaler state
    typedef struct packed {
        logic [2:0] cnt;
    } sbtc_presc_s;
endpackage : sbtc_pkg

// ### common/sbtc_if.sv
// link between the timer core and its prescaler
`timescale 1ns/100ps
`default_nettype none
interface sbtc_if;
    logic       src_tick;  // one pulse per source edge
    logic [1:0] sel;       // prescale select
    logic       clr;       // clear the prescale counter
    logic       tick;      // prescaled count pulse
    modport core  (output src_tick, output sel, output clr, input tick);
    modport presc (input src_tick, input sel, input clr, output tick);
endinterface : sbtc_if
`default_nettype wire

// ### src/sbtc_presc.sv
// prescaler dividing source ticks by 1, 2, 4 or 8
`timescale 1ns/100ps
`default_nettype none
module sbtc_presc (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // link to the core
    sbtc_if.presc     pif
);
    sbtc_pkg::sbtc_presc_s s_q;  // registered state
    sbtc_pkg::sbtc_presc_s s_d;  // next state

    // low bits that must all be ones before a tick passes
    function automatic logic [2:0] ratio_mask(input logic [1:0] sel);
        ratio_mask = 3'((4'h1 << sel) - 4'h1);
    endfunction : ratio_mask

    // a tick passes when the counted low bits are all ones
    assign pif.tick = pif.src_tick && ((s_q.cnt & ratio_mask(pif.sel)) == ratio_mask(pif.sel));

    // counter: clear wins, then count each source tick
    always_comb begin
        s_d = s_q;
        if (pif.clr) begin
            s_d.cnt = 3'h0;
        end else if (pif.tick) begin
            s_d.cnt = 3'h0;
        end else if (pif.src_tick) begin
            s_d.cnt = s_q.cnt + 3'h1;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    a_presc_clear: assert property (@(posedge pclk) disable iff (!presetn)
        pif.clr |=> s_q.cnt == 3'h0) else $error("prescaler not cleared");
    a_presc_ratio: assert property (@(posedge pclk) disable iff (!presetn)
        (pif.src_tick && pif.sel == 2'h3 && s_q.cnt != 3'h7) |-> !pif.tick)
        else $error("divide by eight ticked early");
endmodule : sbtc_presc
`default_nettype wire

// ### dv/sbtc_partner.sv
// far-side model: external count clock and crystal input pins
`timescale 1ns/100ps
`default_nettype none
module sbtc_partner (
    // clock used only to pace pin edges
    input  wire logic pclk,
    // pins toward the timer
    output logic      ext_clock_pin,
    output logic      osc_input_pin
);
    // both sources idle low between bursts, like a gated generator
    initial begin
        ext_clock_pin = 1'b0;
        osc_input_pin = 1'b0;
    end

    // n full periods, 4 cycles high and 4 low: slow enough for the synchroniser
    task automatic burst(input int n, input bit on_osc);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge pclk);
            if (on_osc) begin
                osc_input_pin <= ~osc_input_pin;
            end else begin
                ext_clock_pin <= ~ext_clock_pin;
            end
            repeat (3) @(posedge pclk);
        end
    endtask : burst
endmodule : sbtc_partner
`default_nettype wire

// ### dv/test_sixteen_bit_timer_counter.sv
// self-checking bench for the timer/counter with a behavioural count model
`timescale 1ns/100ps
`default_nettype none
module test_sixteen_bit_timer_counter;
    // design stimulus and responses
    logic        pclk, presetn, soft_reset_n, sleep_req, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, osc_output_pin, osc_enable, irq;
    logic        ext_clock_pin, osc_input_pin;
    // scoreboard and model state
    int          errors, checks_done, mcnt, mflags, n;
    logic [31:0] lo;

    sbtc_top sbtc_top_inst (.pclk(pclk), .presetn(presetn), .soft_reset_n(soft_reset_n),
        .sleep_req(sleep_req), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_clock_pin(ext_clock_pin), .osc_input_pin(osc_input_pin),
        .osc_output_pin(osc_output_pin), .osc_enable(osc_enable), .irq(irq));
    sbtc_partner sbtc_partner_inst (.pclk(pclk), .ext_clock_pin(ext_clock_pin),
        .osc_input_pin(osc_input_pin));

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    // verdict and end of run, shared with the watchdog
    task automatic print_verdict;
        if (errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // one comparison, four-state exact
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input bit wr, input logic [9:0] idx, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            errors++;
            print_verdict();
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // register read compared against expectation
    task automatic rdc(input string what, input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        check(what, rd, exp);
    endtask : rdc

    // count written as two bytes, model follows
    task automatic put_cnt(input int v);
        mcnt = v & 32'h0000_ffff;
        apb(1'b1, sbtc_pkg::IDX_CNT_HI, 32'((mcnt >> 8) & 8'hff));
        apb(1'b1, sbtc_pkg::IDX_CNT_LO, 32'(mcnt & 8'hff));
    endtask : put_cnt

    // count read as two bytes and compared with the model
    task automatic chk_cnt;
        repeat (8) @(posedge pclk);
        apb(1'b0, sbtc_pkg::IDX_CNT_LO, 32'h0000_0000);
        lo = rd;
        apb(1'b0, sbtc_pkg::IDX_CNT_HI, 32'h0000_0000);
        check("count", {16'h0000, rd[7:0], lo[7:0]}, 32'(mcnt));
    endtask : chk_cnt

    // model: ticks after prescale, wrap flag, compare clear without overflow
    task automatic step(input int pulses, input int ps, input bit trig, input int cmp);
        for (int i = 0; i < pulses / (1 << ps); i++) begin
            if (mcnt == 16'hffff) mflags |= 1;
            mcnt = (mcnt + 1) & 16'hffff;
            if (trig && mcnt == cmp) begin
                mcnt = 0;
                mflags |= 4;
            end
        end
    endtask : step

    // watchdog: the whole run needs well under this span
    initial begin
        repeat (40000) @(posedge pclk);
        errors++;
        print_verdict();
    end

    // main sequence
    initial begin
        pclk = 1'b0; presetn = 1'b0; soft_reset_n = 1'b1; sleep_req = 1'b0;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        errors = 0; checks_done = 0; mflags = 0;
        void'($urandom(32'h3b4fd961));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and an unmapped place
        rdc("tctl", sbtc_pkg::IDX_TCTL, 32'h0000_0000);
        rdc("pflags", sbtc_pkg::IDX_PFLAGS, 32'h0000_0000);
        rdc("penables", sbtc_pkg::IDX_PENABLES, 32'h0000_0000);
        rdc("intctl", sbtc_pkg::IDX_INTCTL, 32'h0000_0000);
        apb(1'b0, 10'h001, 32'h0000_0000);
        check("slverr", {31'h0, err}, 32'h0000_0001);
        // count has no reset: give it a known value before any tick reaches it
        put_cnt(0);
        // every prescale ratio on the external pin; stale residue must be dropped
        for (int ps = 0; ps < 4; ps++) begin
            apb(1'b1, sbtc_pkg::IDX_TCTL, 32'((ps << 4) | 3));
            sbtc_partner_inst.burst(3, 1'b0);
            put_cnt($urandom_range(16'hffff, 16'hfff0));
            n = $urandom_range(12, 3);
            sbtc_partner_inst.burst(n, 1'b0);
            step(n, ps, 1'b0, 0);
            chk_cnt();
        end
        // forced wrap, flag set with all enables clear
        apb(1'b1, sbtc_pkg::IDX_TCTL, 32'h0000_0003);
        apb(1'b1, sbtc_pkg::IDX_PFLAGS, 32'h0000_0005);
        mflags = 0;
        put_cnt(16'hffff);
        sbtc_partner_inst.burst(1, 1'b0);
        step(1, 0, 1'b0, 0);
        chk_cnt();
        rdc("ovf flag", sbtc_pkg::IDX_PFLAGS, 32'(mflags));
        // interrupt gating by own, peripheral and global enables
        apb(1'b1, sbtc_pkg::IDX_PENABLES, 32'h0000_0001);
        apb(1'b1, sbtc_pkg::IDX_INTCTL, 32'h0000_0040);
        @(posedge pclk);
        check("irq no global", {31'h0, irq}, 32'h0000_0000);
        apb(1'b1, sbtc_pkg::IDX_INTCTL, 32'h0000_00c0);
        @(posedge pclk);
        check("irq all on", {31'h0, irq}, 32'h0000_0001);
        apb(1'b1, sbtc_pkg::IDX_PFLAGS, 32'h0000_0001);
        @(posedge pclk);
        check("irq cleared", {31'h0, irq}, 32'h0000_0000);
        // compare pair as period: non-trigger mode then trigger mode
        apb(1'b1, sbtc_pkg::IDX_CMP_HI, 32'h0000_0000);
        apb(1'b1, sbtc_pkg::IDX_CMP_LO, 32'h0000_0003);
        for (int m = 10; m < 12; m++) begin
            apb(1'b1, sbtc_pkg::IDX_CMP_MODE, 32'(m));
            apb(1'b1, sbtc_pkg::IDX_PFLAGS, 32'h0000_0005);
            mflags = 0;
            put_cnt(0);
            sbtc_partner_inst.burst(5, 1'b0);
            step(5, 0, m == 11, 3);
            chk_cnt();
        end
        rdc("trig flags", sbtc_pkg::IDX_PFLAGS, 32'(mflags));
        // asynchronous mode: no clear though the trigger mode is still set
        apb(1'b1, sbtc_pkg::IDX_TCTL, 32'h0000_0007);
        put_cnt(0);
        sbtc_partner_inst.burst(5, 1'b0);
        step(5, 0, 1'b0, 0);
        chk_cnt();
        // crystal enabled: pin amplifier live, counts on during sleep
        apb(1'b1, sbtc_pkg::IDX_TCTL, 32'h0000_000f);
        @(posedge pclk);
        check("osc on", {30'h0, osc_enable, osc_output_pin}, 32'h0000_0003);
        sleep_req <= 1'b1;
        sbtc_partner_inst.burst(4, 1'b1);
        step(4, 0, 1'b0, 0);
        chk_cnt();
        sleep_req <= 1'b0;
        apb(1'b1, sbtc_pkg::IDX_TCTL, 32'h0000_0003);
        @(posedge pclk);
        check("osc off", {30'h0, osc_enable, osc_output_pin}, 32'h0000_0000);
        // write meets a trigger every cycle: written value stays
        apb(1'b1, sbtc_pkg::IDX_CMP_LO, 32'h0000_0000);
        // park the count on the compare value so the trigger fires every cycle
        apb(1'b1, sbtc_pkg::IDX_CNT_LO, 32'h0000_0000);
        apb(1'b1, sbtc_pkg::IDX_CNT_LO, 32'h0000_0005);
        mcnt = 5;
        chk_cnt();
        // sleep halts synchronous pin counting and the instruction clock
        apb(1'b1, sbtc_pkg::IDX_CMP_MODE, 32'h0000_0000);
        sleep_req <= 1'b1;
        sbtc_partner_inst.burst(3, 1'b0);
        apb(1'b1, sbtc_pkg::IDX_TCTL, 32'h0000_0001);
        repeat (20) @(posedge pclk);
        apb(1'b1, sbtc_pkg::IDX_TCTL, 32'h0000_0000);
        sleep_req <= 1'b0;
        chk_cnt();
        // internal source: 64 cycles switched on give exactly 16 ticks
        apb(1'b1, sbtc_pkg::IDX_TCTL, 32'h0000_0001);
        repeat (61) @(posedge pclk);
        apb(1'b1, sbtc_pkg::IDX_TCTL, 32'h0000_0000);
        step(16, 0, 1'b0, 0);
        chk_cnt();
        // other reset keeps control and count; power-on reset zeroes control but keeps the count
        apb(1'b1, sbtc_pkg::IDX_TCTL, 32'h0000_0036);
        put_cnt($urandom);
        soft_reset_n <= 1'b0;
        repeat (2) @(posedge pclk);
        soft_reset_n <= 1'b1;
        rdc("tctl soft", sbtc_pkg::IDX_TCTL, 32'h0000_0036);
        rdc("intctl soft", sbtc_pkg::IDX_INTCTL, 32'h0000_0000);
        rdc("pflags soft", sbtc_pkg::IDX_PFLAGS, 32'h0000_0000);
        chk_cnt();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("tctl por", sbtc_pkg::IDX_TCTL, 32'h0000_0000);
        chk_cnt();
        print_verdict();
    end
endmodule : test_sixteen_bit_timer_counter
`default_nettype wire
